// [logic/occ_pkg.sv]
// occ_pkg: constants and types shared by the output compare channel.
// assumes a 16-bit register port with word offsets and one system clock.
package occ_pkg;

  localparam int unsigned DW = 16;
  localparam int unsigned AW = 4;

  // register word offsets
  localparam logic [3:0] OFS_CONTROL   = 4'h0;
  localparam logic [3:0] OFS_PRIMARY   = 4'h1;
  localparam logic [3:0] OFS_SECONDARY = 4'h2;
  localparam logic [3:0] OFS_STATUS    = 4'h3;
  localparam logic [3:0] OFS_MASK      = 4'h4;

  // compare_control field positions
  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned MODE_MSB  = 2;
  localparam int unsigned TSEL_BIT  = 3;
  localparam int unsigned FLT_BIT   = 4;
  localparam int unsigned IDLE_BIT  = 13;
  localparam logic [15:0] CONTROL_WMASK = 16'h200f;

  // interrupt status and mask bits
  localparam int unsigned IRQ_CMP_BIT = 0;
  localparam int unsigned IRQ_FLT_BIT = 1;
  localparam int unsigned IRQ_W       = 2;

  // reset values
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [1:0]  STATUS_RESET  = 2'h0;
  localparam logic [1:0]  MASK_RESET    = 2'h0;

  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_SET_LOW  = 3'h2,
    MODE_TOGGLE   = 3'h3,
    MODE_DELAYED  = 3'h4,
    MODE_CONT     = 3'h5,
    MODE_PWM      = 3'h6,
    MODE_PWM_FLT  = 3'h7
  } occ_mode_type;

  // pulse phase, gray along wait -> pulse -> done
  typedef enum logic [1:0] {
    PH_WAIT  = 2'b00,
    PH_PULSE = 2'b01,
    PH_DONE  = 2'b11
  } occ_phase_type;

endpackage : occ_pkg

// [logic/occ_if.sv]
// occ_if: compare request and match pulses between channel core and comparator.
// assumes both ends run on clk_sys.
`timescale 1ns/10ps
interface occ_if;
  logic                   sel;
  logic                   run;
  logic [occ_pkg::DW-1:0] val_a;
  logic [occ_pkg::DW-1:0] val_b;
  logic                   hit_a;
  logic                   hit_b;
  modport core (output sel, output run, output val_a, output val_b,
                input hit_a, input hit_b);
  modport cmp  (input sel, input run, input val_a, input val_b,
                output hit_a, output hit_b);
endinterface : occ_if

// [logic/occ_match.sv]
// occ_match: selects a time base and compares it with two values.
// assumes the time bases are synchronous counts on clk_sys.
`timescale 1ns/10ps
module occ_match #(
  parameter int unsigned DW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic [DW-1:0] time_base_a,
  input  wire logic [DW-1:0] time_base_b,
  occ_if.cmp                 port
);

  logic [DW-1:0] count;
  logic [DW-1:0] prev;
  logic          fresh;

  assign count = port.sel ? time_base_b : time_base_a; // R1
  // a stopped timer must not keep re-matching the same value
  assign fresh = (count != prev);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev       <= {DW{1'b0}};
      port.hit_a <= 1'b0;
      port.hit_b <= 1'b0;
    end else begin
      prev       <= count;
      port.hit_a <= port.run & fresh & (count == port.val_a); // R2
      port.hit_b <= port.run & fresh & (count == port.val_b); // R2
    end
  end

endmodule : occ_match

// [logic/occ_top.sv]
// occ_top: one output compare channel with register port and interrupt.
// assumes time bases and their rollover pulses come from timers on clk_sys.
//
// Functional notes
// R1 - control bit 3 picks base b, else a
// R2 - compare against one or two values per mode
// R3 - mode 000 off, no interrupt, pin from gpio
// R4 - mode 001 start low, match sets high
// R5 - mode 010 start high, match forces low
// R6 - mode 011 keeps level, match toggles output
// R7 - mode 100 single pulse, interrupt on fall
// R8 - mode 101 repeating pulses, interrupt each fall
// R9 - mode 110 pwm, initial level from primary
// R10 - mode 111 pwm, fault fall interrupts
// R11 - fault status bit 4, hardware clears only; a control write that changes the mode also clears it
// R12 - bit 13 halts channel while cpu idle
// R13 - software stops time base before control writes
// R14 - mode in bits 2:0, all reset zero
// R15 - pulse rises on primary, falls on secondary
// R16 - pwm sets at rollover, clears at duty
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
module occ_top #(
  parameter int unsigned DW = occ_pkg::DW
) (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic [occ_pkg::AW-1:0] reg_addr,
  input  wire logic [DW-1:0]         reg_wdata,
  input  wire logic                  reg_write,
  input  wire logic                  reg_read,
  output logic      [DW-1:0]         reg_rdata,
  input  wire logic [DW-1:0]         time_base_a,
  input  wire logic [DW-1:0]         time_base_b,
  input  wire logic                  rollover_a,
  input  wire logic                  rollover_b,
  input  wire logic                  fault_input_a,
  input  wire logic                  cpu_idle,
  input  wire logic                  gpio_level,
  output logic                       compare_output_pin,
  output logic                       pin_owned,
  output logic                       irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers and decode

  logic [15:0]                    control;
  logic [DW-1:0]                  primary_compare_value;
  logic [DW-1:0]                  secondary_compare_value;
  logic [occ_pkg::IRQ_W-1:0]      status;
  logic [occ_pkg::IRQ_W-1:0]      mask;
  logic                           pwm_fault_status;
  logic                           out_level;
  logic                           fault_prev;
  logic [DW-1:0]                  duty;
  occ_pkg::occ_phase_type         phase;

  occ_pkg::occ_mode_type          compare_mode_field;
  occ_pkg::occ_mode_type          wr_mode;
  logic                           time_base_select;
  logic                           idle_halt_select;
  logic                           wr_control;
  logic                           wr_primary;
  logic                           wr_secondary;
  logic                           wr_mask;
  logic                           rd_status;
  logic                           mode_change;
  logic                           halted;
  logic                           run;
  logic                           is_pwm;
  logic                           rollover;
  logic                           fault_fall;
  logic [15:0]                    control_view;
  logic [DW-1:0]                  rd_value;

  logic                           next_out;
  logic                           next_fault;
  logic [DW-1:0]                  next_duty;
  occ_pkg::occ_phase_type         next_phase;
  logic                           ev_cmp;
  logic                           ev_flt;
  logic [occ_pkg::IRQ_W-1:0]      next_status;

  occ_if link ();

  function automatic logic pwm_level(input logic [DW-1:0] v);
    pwm_level = (v != {DW{1'b0}});
  endfunction : pwm_level

  // level a mode starts from when it is entered
  function automatic logic entry_level(input occ_pkg::occ_mode_type m,
                                       input logic cur,
                                       input logic [DW-1:0] pri);
    case (m)
      occ_pkg::MODE_SET_LOW: entry_level = 1'b1;
      occ_pkg::MODE_TOGGLE:  entry_level = cur;
      occ_pkg::MODE_PWM,
      occ_pkg::MODE_PWM_FLT: entry_level = pwm_level(pri);
      default:               entry_level = 1'b0;
    endcase
  endfunction : entry_level

  assign compare_mode_field =
    occ_pkg::occ_mode_type'(control[occ_pkg::MODE_MSB:occ_pkg::MODE_LSB]); // R14
  assign wr_mode =
    occ_pkg::occ_mode_type'(reg_wdata[occ_pkg::MODE_MSB:occ_pkg::MODE_LSB]);
  assign time_base_select = control[occ_pkg::TSEL_BIT];
  assign idle_halt_select = control[occ_pkg::IDLE_BIT];

  assign wr_control   = reg_write && (reg_addr == occ_pkg::OFS_CONTROL);
  assign wr_primary   = reg_write && (reg_addr == occ_pkg::OFS_PRIMARY);
  assign wr_secondary = reg_write && (reg_addr == occ_pkg::OFS_SECONDARY);
  assign wr_mask      = reg_write && (reg_addr == occ_pkg::OFS_MASK);
  assign rd_status    = reg_read && (reg_addr == occ_pkg::OFS_STATUS);
  assign mode_change  = wr_control && (wr_mode != compare_mode_field);

  assign halted   = idle_halt_select & cpu_idle; // R12
  assign run      = (compare_mode_field != occ_pkg::MODE_OFF) & ~halted; // R3
  assign is_pwm   = (compare_mode_field == occ_pkg::MODE_PWM) ||
                    (compare_mode_field == occ_pkg::MODE_PWM_FLT);
  assign rollover = time_base_select ? rollover_b : rollover_a; // R1
  assign fault_fall = fault_prev & ~fault_input_a;

  assign control_view = (control & occ_pkg::CONTROL_WMASK) |
                        (16'(pwm_fault_status) << occ_pkg::FLT_BIT); // R11

  // unmapped offsets read as zero
  assign rd_value =
    (reg_addr == occ_pkg::OFS_CONTROL)   ? control_view :
    (reg_addr == occ_pkg::OFS_PRIMARY)   ? primary_compare_value :
    (reg_addr == occ_pkg::OFS_SECONDARY) ? secondary_compare_value :
    (reg_addr == occ_pkg::OFS_STATUS)    ? DW'(status) :
    (reg_addr == occ_pkg::OFS_MASK)      ? DW'(mask) : {DW{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // comparator

  assign link.sel   = time_base_select; // R1
  assign link.run   = run;
  // pwm compares against the latched duty, other modes against primary
  assign link.val_a = is_pwm ? duty : primary_compare_value; // R2
  assign link.val_b = secondary_compare_value; // R2

  occ_match #(
    .DW (DW)
  ) u_match (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .time_base_a (time_base_a),
    .time_base_b (time_base_b),
    .port        (link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output sequencing

  always_comb begin
    next_out   = out_level;
    next_fault = pwm_fault_status;
    next_duty  = duty;
    next_phase = phase;
    ev_cmp     = 1'b0;
    ev_flt     = 1'b0;
    if (mode_change) begin
      next_out   = entry_level(wr_mode, out_level, primary_compare_value); // R9
      next_fault = 1'b0;
      next_duty  = primary_compare_value;
      next_phase = occ_pkg::PH_WAIT;
    end else if (run) begin
      case (compare_mode_field)
        occ_pkg::MODE_SET_HIGH: begin
          if (phase == occ_pkg::PH_WAIT && link.hit_a) begin
            next_out   = 1'b1; // R4
            next_phase = occ_pkg::PH_DONE;
            ev_cmp     = 1'b1;
          end
        end
        occ_pkg::MODE_SET_LOW: begin
          if (phase == occ_pkg::PH_WAIT && link.hit_a) begin
            next_out   = 1'b0; // R5
            next_phase = occ_pkg::PH_DONE;
            ev_cmp     = 1'b1;
          end
        end
        occ_pkg::MODE_TOGGLE: begin
          if (link.hit_a) begin
            next_out = ~out_level; // R6
            ev_cmp   = 1'b1;
          end
        end
        occ_pkg::MODE_DELAYED,
        occ_pkg::MODE_CONT: begin
          if (phase == occ_pkg::PH_WAIT && link.hit_a) begin
            next_out   = 1'b1; // R15
            next_phase = occ_pkg::PH_PULSE;
          end else if (phase == occ_pkg::PH_PULSE && link.hit_b) begin
            next_out   = 1'b0; // R15
            ev_cmp     = 1'b1; // R7
            // continuous mode rearms, delayed mode stays finished
            next_phase = (compare_mode_field == occ_pkg::MODE_CONT) ?
                         occ_pkg::PH_WAIT : occ_pkg::PH_DONE; // R8
          end
        end
        occ_pkg::MODE_PWM,
        occ_pkg::MODE_PWM_FLT: begin
          if (compare_mode_field == occ_pkg::MODE_PWM_FLT && fault_fall) begin
            next_fault = 1'b1; // R11
            next_out   = 1'b0;
            ev_flt     = 1'b1; // R10
          end else if (pwm_fault_status) begin
            // fault holds the pin low until a period ends with the input high
            next_out = 1'b0;
            if (rollover && fault_input_a) begin
              next_fault = 1'b0; // R11
              next_duty  = secondary_compare_value;
              next_out   = pwm_level(secondary_compare_value);
            end
          end else if (rollover) begin
            next_duty = secondary_compare_value; // R16
            next_out  = pwm_level(secondary_compare_value); // R16
          end else if (link.hit_a) begin
            next_out = 1'b0; // R16
          end
        end
        default: begin
          next_out = out_level;
        end
      endcase
    end
  end

  // set wins over the read that clears it
  assign next_status = (rd_status ? {occ_pkg::IRQ_W{1'b0}} : status) |
                       {ev_flt, ev_cmp};

  ////////////////////////////////////////////////////////////////////////////
  // state

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      control                 <= occ_pkg::CONTROL_RESET; // R14
      primary_compare_value   <= occ_pkg::COMPARE_RESET;
      secondary_compare_value <= occ_pkg::COMPARE_RESET;
      mask                    <= occ_pkg::MASK_RESET;
    end else begin
      if (wr_control) begin
        control <= reg_wdata & occ_pkg::CONTROL_WMASK;
      end
      if (wr_primary) begin
        primary_compare_value <= reg_wdata;
      end
      if (wr_secondary) begin
        secondary_compare_value <= reg_wdata;
      end
      if (wr_mask) begin
        mask <= reg_wdata[occ_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      out_level        <= 1'b0;
      pwm_fault_status <= 1'b0;
      duty             <= occ_pkg::COMPARE_RESET;
      phase            <= occ_pkg::PH_WAIT;
      status           <= occ_pkg::STATUS_RESET;
      fault_prev       <= 1'b1;
    end else begin
      out_level        <= next_out;
      pwm_fault_status <= next_fault;
      duty             <= next_duty;
      phase            <= next_phase;
      status           <= next_status;
      fault_prev       <= fault_input_a;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata          <= {DW{1'b0}};
      compare_output_pin <= 1'b0;
      pin_owned          <= 1'b0;
    end else begin
      reg_rdata          <= reg_read ? rd_value : {DW{1'b0}};
      // the idle halt bit alone must not take the pin from the port while off
      compare_output_pin <= (compare_mode_field != occ_pkg::MODE_OFF) ? out_level : gpio_level; // R3
      pin_owned          <= (compare_mode_field != occ_pkg::MODE_OFF); // R3
    end
  end

  assign irq = |(status & mask);

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  property p_select;
    link.hit_a |-> $past(time_base_select ? time_base_b : time_base_a) == $past(link.val_a);
  endproperty
  a_select: assert property (p_select) else $error("match without equal base"); // R1

  property p_off;
    compare_mode_field == occ_pkg::MODE_OFF && !mode_change
      |=> !status[occ_pkg::IRQ_CMP_BIT] || $past(status[occ_pkg::IRQ_CMP_BIT]);
  endproperty
  a_off: assert property (p_off) else $error("event raised while off"); // R3

  property p_off_pin;
    compare_mode_field == occ_pkg::MODE_OFF && !mode_change
      |=> compare_output_pin == $past(gpio_level);
  endproperty
  a_off_pin: assert property (p_off_pin) else $error("pin not from gpio"); // R3

  property p_set_high;
    compare_mode_field == occ_pkg::MODE_SET_HIGH && run && !mode_change
      && phase == occ_pkg::PH_WAIT && link.hit_a
      |=> out_level && status[occ_pkg::IRQ_CMP_BIT] ##1 compare_output_pin;
  endproperty
  a_set_high: assert property (p_set_high) else $error("set high failed"); // R4

  property p_set_low;
    compare_mode_field == occ_pkg::MODE_SET_LOW && run && !mode_change
      && phase == occ_pkg::PH_WAIT && link.hit_a
      |=> !out_level && status[occ_pkg::IRQ_CMP_BIT];
  endproperty
  a_set_low: assert property (p_set_low) else $error("force low failed"); // R5

  property p_toggle;
    compare_mode_field == occ_pkg::MODE_TOGGLE && run && !mode_change && link.hit_a
      |=> out_level != $past(out_level);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed"); // R6

  property p_single;
    compare_mode_field == occ_pkg::MODE_DELAYED && phase == occ_pkg::PH_DONE
      && !mode_change |=> !out_level && phase == occ_pkg::PH_DONE;
  endproperty
  a_single: assert property (p_single) else $error("second pulse in one-shot"); // R7

  property p_cont;
    compare_mode_field == occ_pkg::MODE_CONT && run && !mode_change
      && phase == occ_pkg::PH_PULSE && link.hit_b
      |=> !out_level && phase == occ_pkg::PH_WAIT && status[occ_pkg::IRQ_CMP_BIT];
  endproperty
  a_cont: assert property (p_cont) else $error("pulse end wrong"); // R8

  property p_pwm_entry;
    mode_change && (wr_mode == occ_pkg::MODE_PWM)
      |=> out_level == pwm_level($past(primary_compare_value)) && !pwm_fault_status;
  endproperty
  a_pwm_entry: assert property (p_pwm_entry) else $error("pwm start level wrong"); // R9

  property p_fault;
    compare_mode_field == occ_pkg::MODE_PWM_FLT && run && !mode_change && fault_fall
      |=> pwm_fault_status && !out_level && status[occ_pkg::IRQ_FLT_BIT];
  endproperty
  a_fault: assert property (p_fault) else $error("fault not taken"); // R10

  property p_fault_hold;
    pwm_fault_status && !mode_change && !(rollover && fault_input_a)
      |=> pwm_fault_status;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault cleared early"); // R11

  property p_idle;
    halted && !mode_change |=> $stable(out_level) && $stable(phase);
  endproperty
  a_idle: assert property (p_idle) else $error("moved while idle halted"); // R12

  property p_reset;
    disable iff (1'b0) sys_rst |=> control == occ_pkg::CONTROL_RESET && !irq;
  endproperty
  a_reset: assert property (p_reset) else $error("not disabled after reset"); // R14

  property p_rollover;
    is_pwm && run && rollover && !pwm_fault_status && !fault_fall && !mode_change
      |=> duty == $past(secondary_compare_value);
  endproperty
  a_rollover: assert property (p_rollover) else $error("duty not latched"); // R16

  c_toggle: cover property (compare_mode_field == occ_pkg::MODE_TOGGLE && ev_cmp);
  c_cont:   cover property (compare_mode_field == occ_pkg::MODE_CONT && ev_cmp);
  c_fault:  cover property (ev_flt ##[1:20] !pwm_fault_status);
  c_irq:    cover property ($rose(irq));

endmodule : occ_top

// [sim/occ_pin_load.sv]
// occ_pin_load: external load on the compare output pin, counts its rising edges while the channel owns the pin.
// assumes the pin is a registered level on clk_sys.
`timescale 1ns/10ps
module occ_pin_load (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        pin_level,
  input  wire logic        pin_owned,
  output logic      [15:0] rise_count
);
  logic last_level;

  // only edges made while the channel owns the pin reach the load
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      last_level <= 1'b0;
      rise_count <= 16'h0000;
    end else begin
      last_level <= pin_level;
      if (pin_owned && pin_level && !last_level) begin
        rise_count <= rise_count + 16'h0001;
      end
    end
  end
endmodule : occ_pin_load

// [sim/test_output_compare_channel.sv]
// test_output_compare_channel: self-checking bench for occ_top.
// assumes a free counter of period 32 feeds both time bases, base b offset by 16.
`timescale 1ns/10ps
module test_output_compare_channel;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] cnt = 16'h0000;
  logic        run = 1'b0;
  logic        zero = 1'b0;
  logic        tsel = 1'b0;
  logic        fault_input_a = 1'b1;
  logic        cpu_idle = 1'b0;
  logic        gpio_level = 1'b0;
  logic        pin;
  logic        owned;
  logic        irq;
  logic [15:0] rises;
  logic [15:0] lfsr_state = 16'hbe5c;
  logic [15:0] exp_q[$];
  logic        rd_d1 = 1'b0;
  int          fails = 0;
  int          num_checks = 0;
  wire  [15:0] base_b = (cnt + 16'h0010) & 16'h001f;
  wire  [15:0] sel_cnt = tsel ? base_b : cnt;
  wire         roll_a = run && (cnt == 16'h001f);
  wire         roll_b = run && (base_b == 16'h001f);

  occ_top u_occ_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .time_base_a(cnt), .time_base_b(base_b), .rollover_a(roll_a), .rollover_b(roll_b),
    .fault_input_a(fault_input_a), .cpu_idle(cpu_idle), .gpio_level(gpio_level),
    .compare_output_pin(pin), .pin_owned(owned), .irq(irq)
  );
  occ_pin_load u_occ_pin_load (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .pin_level(pin), .pin_owned(owned),
    .rise_count(rises)
  );

  always #12.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    if (zero) begin
      cnt <= 16'h0000;
    end else if (run) begin
      cnt <= (cnt == 16'h001f) ? 16'h0000 : cnt + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // the watcher below compares the data when it appears
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
  endtask : rd

  // the time base is stopped around every control write
  task automatic stop_t;
    @(posedge clk_sys);
    run  <= 1'b0;
    zero <= 1'b1;
    @(posedge clk_sys);
    zero <= 1'b0;
  endtask : stop_t

  task automatic run_to(input logic [15:0] t);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      #1;
      if (sel_cnt == t) return;
    end
    chk("run_to timeout", sel_cnt, t);
    report_and_stop();
  endtask : run_to

  // read data stands only in the cycle after the strobe
  always @(posedge clk_sys) rd_d1 <= reg_read;
  // rd_d1 is high exactly while the answer to a read stands
  always @(negedge clk_sys) begin
    if (rd_d1) begin
      if (exp_q.size() == 0) chk("read queue", 16'h0001, 16'h0000);
      else chk("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] pv, sv, r0;
    logic        e0, e1, e2, lvl, cur;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("pin_owned", 16'(owned), 16'h0000);
    for (int a = 0; a < 6; a++) rd(a[3:0], 16'h0000);
    // idle halt armed while off: the port must still own the pin
    wr(occ_pkg::OFS_CONTROL, 16'h2000);
    cpu_idle <= 1'b1;
    cur = 1'b1;
    gpio_level <= cur;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      chk("gpio pin", 16'(pin), 16'(cur));
      chk("irq", 16'(irq), 16'h0000);
      lfsr_state = next_rand(lfsr_state);
      cur = lfsr_state[0];
      gpio_level <= cur;
    end
    wr(occ_pkg::OFS_CONTROL, 16'hffff);
    rd(occ_pkg::OFS_CONTROL, 16'h200f);
    wr(occ_pkg::OFS_MASK, 16'hffff);
    rd(occ_pkg::OFS_MASK, 16'h0003);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h0000);
    wr(occ_pkg::OFS_CONTROL, 16'h0000);
    lvl = 1'b0;
    for (int m = 1; m < 6; m++) begin
      lfsr_state = next_rand(lfsr_state);
      pv = 16'h0004 + {13'h0000, lfsr_state[2:0]};
      sv = pv + 16'h000a;
      stop_t();
      tsel = m[0];
      wr(occ_pkg::OFS_PRIMARY, pv);
      wr(occ_pkg::OFS_SECONDARY, sv);
      wr(occ_pkg::OFS_MASK, 16'(m[0]));
      wr(occ_pkg::OFS_CONTROL, {12'h000, m[0], m[2:0]});
      e0 = (m == 3) ? lvl : (m == 2);
      e1 = (m == 3) ? !lvl : (m != 2);
      e2 = (m >= 4) ? 1'b0 : e1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("entry pin", 16'(pin), 16'(e0));
      chk("pin_owned", 16'(owned), 16'h0001);
      run <= 1'b1;
      run_to(pv + 16'h0002);
      chk("pin before match", 16'(pin), 16'(e0));
      run_to(pv + 16'h0004);
      chk("pin after match", 16'(pin), 16'(e1));
      run_to(sv + 16'h0002);
      chk("pin before second", 16'(pin), 16'(e1));
      run_to(sv + 16'h0004);
      chk("pin after second", 16'(pin), 16'(e2));
      chk("irq masked", 16'(irq), 16'(m[0]));
      rd(occ_pkg::OFS_STATUS, 16'h0001);
      rd(occ_pkg::OFS_STATUS, 16'h0000);
      chk("irq cleared", 16'(irq), 16'h0000);
      if (m >= 4) begin
        r0 = rises;
        run_to(pv + 16'h0004);
        @(posedge clk_sys);
        #1;
        chk("repeat pulses", rises - r0, 16'(m == 5));
      end
      lvl = e2;
    end
    stop_t();
    tsel = 1'b0;
    wr(occ_pkg::OFS_PRIMARY, 16'h0008);
    wr(occ_pkg::OFS_CONTROL, 16'h2003);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    lvl = pin;
    run <= 1'b1;
    run_to(16'h000c);
    chk("idle halted pin", 16'(pin), 16'(lvl));
    stop_t();
    wr(occ_pkg::OFS_CONTROL, 16'h0003);
    run <= 1'b1;
    run_to(16'h000c);
    chk("idle running pin", 16'(pin), 16'(!lvl));
    rd(occ_pkg::OFS_STATUS, 16'h0001);
    stop_t();
    cpu_idle <= 1'b0;
    wr(occ_pkg::OFS_PRIMARY, 16'h0000);
    wr(occ_pkg::OFS_CONTROL, 16'h0006);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pwm zero entry", 16'(pin), 16'h0000);
    wr(occ_pkg::OFS_CONTROL, 16'h0000);
    wr(occ_pkg::OFS_PRIMARY, 16'h0005);
    wr(occ_pkg::OFS_SECONDARY, 16'h000c);
    wr(occ_pkg::OFS_MASK, 16'h0003);
    wr(occ_pkg::OFS_CONTROL, 16'h0006);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("pwm entry", 16'(pin), 16'h0001);
    run <= 1'b1;
    run_to(16'h0003);
    fault_input_a <= 1'b0;
    run_to(16'h000a);
    chk("pwm duty fall", 16'(pin), 16'h0000);
    fault_input_a <= 1'b1;
    run_to(16'h0006);
    chk("pwm period rise", 16'(pin), 16'h0001);
    run_to(16'h0010);
    chk("pwm latched duty", 16'(pin), 16'h0000);
    rd(occ_pkg::OFS_STATUS, 16'h0000);
    rd(occ_pkg::OFS_CONTROL, 16'h0006);
    stop_t();
    wr(occ_pkg::OFS_MASK, 16'h0002);
    wr(occ_pkg::OFS_CONTROL, 16'h0007);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("fault pwm entry", 16'(pin), 16'h0001);
    run <= 1'b1;
    run_to(16'h0003);
    fault_input_a <= 1'b0;
    run_to(16'h0008);
    chk("fault forces low", 16'(pin), 16'h0000);
    chk("fault irq", 16'(irq), 16'h0001);
    rd(occ_pkg::OFS_CONTROL, 16'h0017);
    rd(occ_pkg::OFS_STATUS, 16'h0002);
    run_to(16'h0006);
    chk("fault holds low", 16'(pin), 16'h0000);
    fault_input_a <= 1'b1;
    run_to(16'h0006);
    chk("fault recovered", 16'(pin), 16'h0001);
    rd(occ_pkg::OFS_CONTROL, 16'h0007);
    repeat (3) @(posedge clk_sys);
    report_and_stop();
  end
endmodule : test_output_compare_channel
